//--- logic/qwa_core.sv
// Purpose: Command interpreter for a four-channel nonvolatile wiper device.
// Assumes: A serial front end delivers whole 16-bit commands with a one-cycle strobe.
// Notes: Stored memory is a small register array; write time is not modelled.
//
// What this block does
// - Address MSB set broadcasts to all channels, but hits no channel for stored memory commands
// - Low address bits pick one channel
// - A-side registers only in gain mode
// - Cleared bit 0 blocks wiper writes; a stored restore still moves them
// - Cleared bit 1 blocks nonvolatile programming
// - Bit 2 selects potentiometer or gain mode
// - Bit 3 burst enable is only stored, for the front end
// - Wiper code 7 or 8 bits wide
// - Pot mode: A side is complement code
// - Gain mode: A side from own register
// - Top and bottom scale extra states
// - Opcode 1101 loads the settings bits
// - Opcode 0001 writes wiper if permitted
// - Opcode 1000 writes stored memory if permitted
`timescale 1ns/1ps
module qwa_core #(
   parameter bit POS_256 = 1'b1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   output logic [3:0] operating_settings,
   output logic [31:0] wiper_to_b_code,
   output logic [31:0] a_to_wiper_code,
   output logic [3:0] top_scale,
   output logic [3:0] bottom_scale,
   output logic [31:0] stored_code,
   output logic cmd_refused
);
   // ----------------------------------------
   // Reset synchroniser
   // ----------------------------------------
   logic rst_meta_n;
   logic rst_n;

   // Release is delayed two edges so every register leaves reset together.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // ----------------------------------------
   // Command fields
   // ----------------------------------------
   logic [3:0] opc;
   logic [3:0] addr;
   logic [7:0] data;
   logic [7:0] code_mask;
   logic [7:0] targets;
   logic nvm_op;
   logic wiper_permit;
   logic nvm_permit;
   logic gain_mode;

   assign opc = cmd_word[qwa_pkg::OPC_MSB:qwa_pkg::OPC_LSB];
   assign addr = cmd_word[qwa_pkg::ADR_MSB:qwa_pkg::ADR_LSB];
   assign data = cmd_word[qwa_pkg::DAT_MSB:0];
   assign code_mask = POS_256 ? qwa_pkg::MASK_256 : qwa_pkg::MASK_128;
   assign nvm_op = (opc == qwa_pkg::OP_NV_XFER) || (opc == qwa_pkg::OP_WR_NVM);
   assign wiper_permit = operating_settings[qwa_pkg::WIPER_WRITE_PERMIT_BIT];
   assign nvm_permit = operating_settings[qwa_pkg::NVM_PROGRAM_PERMIT_BIT];
   assign gain_mode = operating_settings[qwa_pkg::GAIN_MODE_SELECT_BIT];

   qwa_target_decode u_decode (
      .addr(addr),
      .gain_mode(gain_mode),
      .nvm_op(nvm_op),
      .targets(targets)
   );

   // ----------------------------------------
   // Operating settings
   // ----------------------------------------
   // Burst bit is only stored here; the I2C front end reads it and keeps burst across stops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         operating_settings <= qwa_pkg::SETTINGS_RESET;
      end else if (cmd_valid && opc == qwa_pkg::OP_SETTINGS) begin
         operating_settings <= cmd_word[3:0];
      end
   end

   // ----------------------------------------
   // Registers per target
   // ----------------------------------------
   logic [7:0] wiper [qwa_pkg::TARGETS];
   logic [7:0] input_reg [qwa_pkg::TARGETS];
   logic [7:0] stored [qwa_pkg::CHANNELS];
   logic [qwa_pkg::TARGETS-1:0] top_flag;
   logic [qwa_pkg::TARGETS-1:0] bot_flag;

   genvar g;
   generate
      for (g = 0; g < qwa_pkg::TARGETS; g++) begin : g_tgt
         // Wiper update; while protected only a stored restore may move it.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               wiper[g] <= 8'h00;
            end else if (cmd_valid && targets[g]) begin
               if (opc == qwa_pkg::OP_NV_XFER && !cmd_word[0] && g < qwa_pkg::CHANNELS) begin
                  wiper[g] <= stored[g % qwa_pkg::CHANNELS];
               end else if (wiper_permit) begin
                  unique case (opc)
                     qwa_pkg::OP_WR_WIPER: wiper[g] <= data & code_mask;
                     qwa_pkg::OP_COPY_IN: wiper[g] <= input_reg[g];
                     qwa_pkg::OP_STEP_LIN: begin
                        if (cmd_word[0] && wiper[g] != code_mask) begin
                           wiper[g] <= wiper[g] + 8'h01;
                        end else if (!cmd_word[0] && wiper[g] != 8'h00) begin
                           wiper[g] <= wiper[g] - 8'h01;
                        end
                     end
                     qwa_pkg::OP_STEP_DB: begin
                        if (cmd_word[0]) begin
                           wiper[g] <= (wiper[g] == 8'h00) ? 8'h01 :
                              (wiper[g] > (code_mask >> 1)) ? code_mask : ((wiper[g] << 1) & code_mask);
                        end else begin
                           wiper[g] <= wiper[g] >> 1;
                        end
                     end
                     default: wiper[g] <= wiper[g];
                  endcase
               end
            end
         end

         // Input register stages a value for a later copy.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               input_reg[g] <= 8'h00;
            end else if (cmd_valid && targets[g] && opc == qwa_pkg::OP_WR_INPUT) begin
               input_reg[g] <= data & code_mask;
            end
         end

         // Scale states sit beside the normal codes; the codes are left unchanged.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               top_flag[g] <= 1'b0;
               bot_flag[g] <= 1'b0;
            end else if (cmd_valid && targets[g] && opc == qwa_pkg::OP_SCALE && wiper_permit) begin
               if (cmd_word[qwa_pkg::SCALE_TOP_BIT]) begin
                  top_flag[g] <= !cmd_word[0];
                  bot_flag[g] <= 1'b0;
               end else begin
                  bot_flag[g] <= cmd_word[0];
                  top_flag[g] <= 1'b0;
               end
            end
         end
      end

      for (g = 0; g < qwa_pkg::CHANNELS; g++) begin : g_nvm
         // Stored memory writes need the programming permit.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stored[g] <= 8'h00;
            end else if (cmd_valid && targets[g] && nvm_permit) begin
               if (opc == qwa_pkg::OP_WR_NVM) begin
                  stored[g] <= data & code_mask;
               end else if (opc == qwa_pkg::OP_NV_XFER && cmd_word[0]) begin
                  stored[g] <= wiper[g];
               end
            end
         end

         // Outputs are registered; A side is complement in pot mode.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               wiper_to_b_code[g*8 +: 8] <= 8'h00;
               a_to_wiper_code[g*8 +: 8] <= 8'h00;
               stored_code[g*8 +: 8] <= 8'h00;
               top_scale[g] <= 1'b0;
               bottom_scale[g] <= 1'b0;
            end else begin
               wiper_to_b_code[g*8 +: 8] <= wiper[g];
               a_to_wiper_code[g*8 +: 8] <= gain_mode ? wiper[g + qwa_pkg::CHANNELS]
                                          : (code_mask - wiper[g]);
               stored_code[g*8 +: 8] <= stored[g];
               top_scale[g] <= top_flag[g];
               bottom_scale[g] <= bot_flag[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Refusal report
   // ----------------------------------------
   // One-cycle pulse when a command other than a settings load hits no target or is blocked by a permit bit.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_refused <= 1'b0;
      end else begin
         cmd_refused <= cmd_valid && opc != qwa_pkg::OP_SETTINGS &&
            (targets == 8'h00 ||
             ((opc == qwa_pkg::OP_WR_NVM || (opc == qwa_pkg::OP_NV_XFER && cmd_word[0])) && !nvm_permit) ||
             ((opc == qwa_pkg::OP_WR_WIPER || opc == qwa_pkg::OP_COPY_IN || opc == qwa_pkg::OP_STEP_LIN ||
               opc == qwa_pkg::OP_STEP_DB || opc == qwa_pkg::OP_SCALE) && !wiper_permit));
      end
   end
endmodule

//--- logic/qwa_pkg.sv
// Purpose: Shared constants for the quad wiper address and control block.
// Assumes: 16-bit command words; opcode in [15:12], address in [11:8], data in [7:0].
// Notes: Settings reset values follow the documented defaults.
package qwa_pkg;
   // ----------------------------------------
   // Command word fields
   // ----------------------------------------
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 12;
   localparam int ADR_MSB = 11;
   localparam int ADR_LSB = 8;
   localparam int DAT_MSB = 7;
   localparam int BROADCAST_SELECT_BIT = 3;
   localparam int A_SIDE_SELECT_BIT = 2;
   localparam int SCALE_TOP_BIT = 7;
   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [3:0] OP_WR_WIPER = 4'h1;
   localparam logic [3:0] OP_WR_INPUT = 4'h2;
   localparam logic [3:0] OP_STEP_LIN = 4'h4;
   localparam logic [3:0] OP_STEP_DB = 4'h5;
   localparam logic [3:0] OP_COPY_IN = 4'h6;
   localparam logic [3:0] OP_NV_XFER = 4'h7;
   localparam logic [3:0] OP_WR_NVM = 4'h8;
   localparam logic [3:0] OP_SCALE = 4'h9;
   localparam logic [3:0] OP_SETTINGS = 4'hD;
   // ----------------------------------------
   // Operating settings register
   // ----------------------------------------
   localparam int WIPER_WRITE_PERMIT_BIT = 0;
   localparam int NVM_PROGRAM_PERMIT_BIT = 1;
   localparam int GAIN_MODE_SELECT_BIT = 2;
   localparam int BURST_ENABLE_BIT = 3;
   localparam logic [3:0] SETTINGS_RESET = 4'h3;
   // ----------------------------------------
   // Wiper geometry
   // ----------------------------------------
   localparam int CHANNELS = 4;
   localparam int TARGETS = 8;
   localparam int CODE_W = 8;
   localparam logic [7:0] MASK_128 = 8'h7F;
   localparam logic [7:0] MASK_256 = 8'hFF;
endpackage

//--- logic/qwa_target_decode.sv
// Purpose: Turns a 4-bit channel address into a target mask, one-hot or broadcast.
// Assumes: Targets 0..3 are B-side wipers, 4..7 are A-side registers.
// Notes: Pure combinational; the caller registers all effects.
`timescale 1ns/1ps
module qwa_target_decode (
   input wire logic [3:0] addr,
   input wire logic gain_mode,
   input wire logic nvm_op,
   output logic [7:0] targets
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Broadcast, single channel, or A-side only in gain mode.
   always_comb begin
      targets = 8'h00;
      if (addr[qwa_pkg::BROADCAST_SELECT_BIT]) begin
         if (!nvm_op) begin
            targets = gain_mode ? 8'hFF : 8'h0F;
         end
      end else if (!addr[qwa_pkg::A_SIDE_SELECT_BIT]) begin
         targets[addr[1:0]] = 1'b1;
      end else if (gain_mode && !nvm_op) begin
         targets[{1'b1, addr[1:0]}] = 1'b1;
      end
   end
endmodule

//--- test/qwa_core_sva.sv
// Purpose: Port checks for the command interpreter.
// Assumes: Codes show two edges after a command.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module qwa_core_chk #(
   parameter bit POS_256 = 1'b1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   input wire logic [3:0] operating_settings,
   input wire logic [31:0] wiper_to_b_code,
   input wire logic [31:0] a_to_wiper_code,
   input wire logic [31:0] stored_code,
   input wire logic cmd_refused
);
   localparam logic [7:0] M = POS_256 ? qwa_pkg::MASK_256 : qwa_pkg::MASK_128;
   // Field views; w1 is a wiper write aimed at one B-side channel.
   wire logic [3:0] op = cmd_word[15:12], ad = cmd_word[11:8], s = operating_settings;
   wire logic [7:0] d = cmd_word[7:0] & M, ch = {3'h0, cmd_word[9:8], 3'h0};
   wire logic go = cmd_valid && ad[3:2] == 2'b00, w1 = go && s[0] && op == 4'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_load; cmd_valid && op == 4'hD |=> s == $past(cmd_word[3:0]); endproperty
   a_load: assert property (p_load) else $error("settings not loaded");
   property p_prot; cmd_valid && !s[0] && op inside {4'h1, 4'h4, 4'h5, 4'h6, 4'h9} |=> cmd_refused; endproperty
   a_prot: assert property (p_prot) else $error("protected change taken");
   property p_nvm; cmd_valid && !s[1] && op == 4'h8 |=> cmd_refused; endproperty
   a_nvm: assert property (p_nvm) else $error("store taken while locked");
   property p_aside; cmd_valid && !s[2] && ad[3:2] == 2'b01 && op inside {4'h1, 4'h2} |=> cmd_refused; endproperty
   a_aside: assert property (p_aside) else $error("A side taken in pot mode");
   property p_bcast; cmd_valid && s[0] && op == 4'h1 && ad[3] |=> ##1 wiper_to_b_code == {4{$past(d, 2)}}; endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast missed");
   property p_one; w1 |=> ##1 wiper_to_b_code[$past(ch, 2) +: 8] == $past(d, 2); endproperty
   a_one: assert property (p_one) else $error("wiper write missed");
   property p_comp; w1 && !s[2] ##1 !cmd_valid |=> a_to_wiper_code[$past(ch, 2) +: 8] == M - $past(d, 2); endproperty
   a_comp: assert property (p_comp) else $error("A side not complement");
   property p_store; go && s[1] && op == 4'h8 |=> ##1 stored_code[$past(ch, 2) +: 8] == $past(d, 2); endproperty
   a_store: assert property (p_store) else $error("store missed");
endmodule

//--- test/qwa_host_model.sv
// Purpose: Host that sends command words.
// Assumes: One word per one-cycle strobe.
// Notes: Idle word is the inverse of the last.
`timescale 1ns/1ps
module qwa_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [15:0] cmd_word
);
   // Bus starts idle.
   initial {cmd_valid, cmd_word} = 17'h0;
   // Strobe one word after an edge; a stale word is never left up.
   task automatic send(input logic [15:0] w);
      @(posedge clk);
      #1 {cmd_valid, cmd_word} = {1'b1, w};
      @(posedge clk);
      #1 {cmd_valid, cmd_word} = {1'b0, ~w};
   endtask
endmodule

//--- test/qwa_core_tb.sv
// Purpose: Self-checking bench for the command interpreter.
// Assumes: 7-bit codes; three cycles per command.
// Notes: Expected values come only from predict.
`timescale 1ns/1ps
module qwa_core_tb;
   logic clk = 1'b0, arst_n = 1'b0, cmd_valid, cmd_refused, rf;
   logic [15:0] cmd_word;
   logic [3:0] operating_settings, top_scale, bottom_scale, s = qwa_pkg::SETTINGS_RESET;
   logic [31:0] wiper_to_b_code, a_to_wiper_code, stored_code, ea;
   logic [7:0] wb[4] = '{default: 8'h00}, as[4] = '{default: 8'h00}, st[4] = '{default: 8'h00};
   logic [3:0] ts = 4'h0, bs = 4'h0;
   // The protect-off word proves refusal; permits are restored before the scale words.
   logic [15:0] cw[12] = '{16'h18FF, 16'h1455, 16'hD007, 16'h1633, 16'h18A5, 16'h8355, 16'h8C11, 16'hD004,
      16'h1012, 16'hD003, 16'h9F80, 16'h9101};
   logic [3:0] ops[4] = '{4'h1, 4'h8, 4'hD, 4'h1};
   integer seed = 32'h941426CB, r;
   int n_errors = 0, comparisons = 0;
   // Free-running clock.
   always #50 clk = ~clk;
   qwa_core #(.POS_256(1'b0)) dut (.clk, .arst_n, .cmd_valid, .cmd_word, .operating_settings,
      .wiper_to_b_code, .a_to_wiper_code, .top_scale, .bottom_scale, .stored_code, .cmd_refused);
   qwa_host_model host (.clk, .cmd_valid, .cmd_word);
   // Counts every compare and reports a difference at once.
   task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      n_errors += int'(seen !== exp);
      if (seen !== exp) $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
   endtask
   // Prints counts and verdict, then stops.
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reference model; returns 1 when the command is refused.
   function automatic logic predict(input logic [15:0] w);
      logic [3:0] a;
      logic [7:0] d;
      a = w[11:8];
      d = w[7:0] & qwa_pkg::MASK_128;
      if (w[15:12] == 4'hD) s = w[3:0];
      if (w[15:12] == 4'h8 && (a[3:2] != 2'b00 || !s[1])) return 1'b1;
      if (w[15:12] == 4'h8) st[a[1:0]] = d;
      if (w[15:12] == 4'h9) begin
         if (!s[0] || a[3:2] == 2'b01 && !s[2]) return 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (a[3] || a[3:2] == 2'b00 && a[1:0] == i[1:0]) begin
               ts[i] = w[7] ? !w[0] : 1'b0;
               bs[i] = w[7] ? 1'b0 : w[0];
            end
         end
         return 1'b0;
      end
      if (w[15:12] != 4'h1) return 1'b0;
      if (!s[0] || a[3:2] == 2'b01 && !s[2]) return 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (a[3] || a[1:0] == i[1:0]) begin
            if (a[3] || !a[2]) wb[i] = d;
            if (s[2] && (a[3] || a[2])) as[i] = d;
         end
      end
      return 1'b0;
   endfunction
   // One word; send returns just after the taking edge, where the refusal pulse stands for one cycle.
   task automatic step(input logic [15:0] w);
      host.send(w);
      rf = predict(w);
      for (int i = 0; i < 4; i++) ea[8*i+:8] = s[2] ? as[i] : qwa_pkg::MASK_128 - wb[i];
      ck("refused", {31'h0, cmd_refused}, {31'h0, rf});
      ck("settings", {28'h0, operating_settings}, {28'h0, s});
      @(posedge clk);
      #1 ck("wiper_b", wiper_to_b_code, {wb[3], wb[2], wb[1], wb[0]});
      ck("wiper_a", a_to_wiper_code, ea);
      ck("stored", stored_code, {st[3], st[2], st[1], st[0]});
      ck("top_scale", {28'h0, top_scale}, {28'h0, ts});
      ck("bottom_scale", {28'h0, bottom_scale}, {28'h0, bs});
   endtask
   // Reset, corner words, then a seeded random stream.
   initial begin
      repeat (4) @(posedge clk);
      #1 ck("reset", {28'h0, operating_settings} | wiper_to_b_code | stored_code, {28'h0, s});
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      foreach (cw[i]) step(cw[i]);
      repeat (300) begin
         r = $random(seed);
         step({ops[r[17:16]], r[11:0]});
      end
      tally_and_finish();
   end
endmodule
bind qwa_core qwa_core_chk #(.POS_256(POS_256)) chk (.clk, .arst_n, .cmd_valid, .cmd_word,
   .operating_settings, .wiper_to_b_code, .a_to_wiper_code, .stored_code, .cmd_refused);
